/* verilog/ddl_regs.svh */
// word layout and timing constants of the dual converter word loader
`ifndef DDL_REGS_SVH
`define DDL_REGS_SVH
`define DDL_WORD_BITS 16
`define DDL_DATA_BITS 12
`define DDL_SEL_HI_POS 15
`define DDL_SPEED_POS 14
`define DDL_PWRDN_POS 13
`define DDL_SEL_LO_POS 12
`define DDL_DATA_MSB 11
`define DDL_CODE_RESET 12'h000
`define DDL_COUNT_LAST 5'h10
`endif

/* verilog/ddl_pkg.sv */
// types of the dual converter word loader
package ddl_pkg;
  typedef enum logic [1:0] {
    SEL_B_AND_BUF,
    SEL_BUF_ONLY,
    SEL_A_COPY_B,
    SEL_RESERVED
  } ddl_sel_t;
  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [1:0] din_sync;
    logic [15:0] shift;
    logic [4:0] count;
    logic active;
    logic pending;
    logic [11:0] code_a;
    logic [11:0] code_b;
    logic [11:0] hold_buf;
    logic speed_fast;
    logic power_down;
    logic update;
  } ddl_state_t;
endpackage : ddl_pkg

/* verilog/ddl_loader.sv */
// serial word loader and latch update logic of a dual 12-bit converter
// Overview of operation
// R1: a falling chip select starts a transfer and data is shifted in msb first on falling serial clock edges.
// R2: after sixteen bits, or an earlier chip select rise after at least one bit, the word is moved into the selected latches.
// R3: the word is sixteen bits: four program bits on top, twelve data bits below, msb first.
// R4: select code 00 loads channel b and the buffer, code 01 loads only the buffer.
// R5: select code 10 loads channel a and copies the buffer into channel b at once; code 11 is reserved.
// R6: the twelve data bits become the unsigned code of each targeted latch.
// R7: bit 14 selects fast settling when one and slow when zero, applied with each accepted word that has bit 13 clear.
// R8: a word with bit 13 set enters power-down and its other bits are ignored.
// R9: latches update on the rising serial clock edge after the sixteenth falling edge.
// R10: the host updates both outputs together by a buffer-only word then a code 10 word.
// R11: the host lowers chip select before clocking; an 8-bit port sends two writes per word.
// R12: reset clears every latch and program setting to zero.
// R13: a reserved code 11 word leaves all data latches alone, and clock edges with chip select high are ignored.
`timescale 1ns/1ps
`include "ddl_regs.svh"
module ddl_loader (
  input wire logic i_mclk,            // system clock 100 MHz
  input wire logic i_reset_n,         // async reset, active low
  input wire logic i_sclk,            // serial clock pin
  input wire logic i_cs_n,            // chip select pin, active low
  input wire logic i_din,             // serial data pin
  output logic [11:0] o_code_a,       // channel a output code
  output logic [11:0] o_code_b,       // channel b output code
  output logic [11:0] o_hold_buf,     // holding buffer
  output logic o_speed_fast,          // settling speed select
  output logic o_power_down,          // power-down state
  output logic o_update               // one-cycle latch update pulse
);
  ddl_pkg::ddl_state_t state_reg;
  ddl_pkg::ddl_state_t state_next;
  logic sclk_fall;
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic commit;
  logic [15:0] word;
  ddl_pkg::ddl_sel_t sel;

  assign sclk_fall = state_reg.sclk_sync[2] & ~state_reg.sclk_sync[1];
  assign sclk_rise = ~state_reg.sclk_sync[2] & state_reg.sclk_sync[1];
  assign cs_fall = state_reg.cs_sync[2] & ~state_reg.cs_sync[1];
  assign cs_rise = ~state_reg.cs_sync[2] & state_reg.cs_sync[1];
  assign cs_low = ~state_reg.cs_sync[1];

  always_comb begin
    state_next = state_reg;
    word = state_reg.shift;
    commit = 1'b0;
    state_next.sclk_sync = {state_reg.sclk_sync[1:0], i_sclk};
    state_next.cs_sync = {state_reg.cs_sync[1:0], i_cs_n};
    state_next.din_sync = {state_reg.din_sync[0], i_din};
    state_next.update = 1'b0;
    if (cs_fall) begin
      state_next.active = 1'b1; // R1
      state_next.count = 5'h00;
      state_next.shift = 16'h0000; // no stale bits in a cut frame
      state_next.pending = 1'b0;
    end else if (state_reg.active && cs_low && sclk_fall && !state_reg.pending) begin
      // msb first shift on falling clock edges
      state_next.shift = {state_reg.shift[14:0], state_reg.din_sync[1]}; // R1 R3
      state_next.count = state_reg.count + 5'h01;
      if (state_reg.count + 5'h01 == `DDL_COUNT_LAST) begin
        state_next.pending = 1'b1;
      end
    end else if (state_reg.active && state_reg.pending && sclk_rise) begin
      commit = 1'b1; // R9
      state_next.active = 1'b0;
      state_next.pending = 1'b0;
    end else if (state_reg.active && cs_rise) begin
      // early rise: take the word as it stands
      commit = state_reg.count != 5'h00; // R2
      state_next.active = 1'b0;
      state_next.pending = 1'b0;
    end
    sel = ddl_pkg::ddl_sel_t'({word[`DDL_SEL_HI_POS], word[`DDL_SEL_LO_POS]});
    if (commit) begin
      state_next.update = 1'b1;
      if (word[`DDL_PWRDN_POS]) begin
        state_next.power_down = 1'b1; // R8
      end else begin
        state_next.power_down = 1'b0;
        state_next.speed_fast = word[`DDL_SPEED_POS]; // R7
        case (sel)
          ddl_pkg::SEL_B_AND_BUF: begin
            state_next.code_b = word[`DDL_DATA_MSB:0]; // R4 R6
            state_next.hold_buf = word[`DDL_DATA_MSB:0];
          end
          ddl_pkg::SEL_BUF_ONLY: begin
            state_next.hold_buf = word[`DDL_DATA_MSB:0]; // R4
          end
          ddl_pkg::SEL_A_COPY_B: begin
            state_next.code_a = word[`DDL_DATA_MSB:0]; // R5 R6
            state_next.code_b = state_reg.hold_buf;
          end
          default: begin
            state_next.code_a = state_reg.code_a; // R13
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '0; // R12
      state_reg.sclk_sync <= 3'h7; // pin idles high, no false edge
      state_reg.cs_sync <= 3'h7;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_code_a = state_reg.code_a;
  assign o_code_b = state_reg.code_b;
  assign o_hold_buf = state_reg.hold_buf;
  assign o_speed_fast = state_reg.speed_fast;
  assign o_power_down = state_reg.power_down;
  assign o_update = state_reg.update;

  // steps of a transfer, as the checks below see them
  sequence s_bit_taken;
    state_reg.active && cs_low && sclk_fall && !state_reg.pending && !cs_fall;
  endsequence

  sequence s_word_commit;
    state_reg.pending && state_reg.active && sclk_rise;
  endsequence

  sequence s_word_wait;
    state_reg.pending && !sclk_rise && !cs_fall && !cs_rise;
  endsequence

  sequence s_frame_cut;
    state_reg.active && cs_rise && !sclk_fall && !state_reg.pending && state_reg.count != 5'h00;
  endsequence

  sequence s_empty_cut;
    state_reg.active && cs_rise && !state_reg.pending && state_reg.count == 5'h00;
  endsequence

  sequence s_word_taken;
    commit && !word[`DDL_PWRDN_POS];
  endsequence

  // framing and shifting
  a_cs_arm: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R1
    cs_fall |=> (state_reg.active && state_reg.count == 5'h00 && state_reg.shift == 16'h0000)
  ) else $error("chip select fall did not arm");

  a_shift_msb: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R1
    s_bit_taken |=> state_reg.shift == {$past(state_reg.shift[14:0]), $past(state_reg.din_sync[1])}
  ) else $error("bit not shifted msb first");

  a_bit_count: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R3
    s_bit_taken |=> state_reg.count == $past(state_reg.count) + 5'h01
  ) else $error("bit count not advanced");

  a_count_limit: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R3
    state_reg.count <= `DDL_COUNT_LAST
  ) else $error("more than sixteen bits taken");

  a_idle_ignore: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R13
    (!cs_low && !cs_rise) |=> $stable(state_reg.shift)
  ) else $error("shift moved with select high");

  // moment of the latch update
  a_rise_update: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R9
    s_word_commit |=> o_update
  ) else $error("no update after rising edge");

  a_no_early_update: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R9
    s_word_wait |=> !o_update
  ) else $error("update before rising edge");

  a_early_commit: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R2
    s_frame_cut |=> o_update
  ) else $error("chip select rise did not commit");

  a_empty_cut: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R2
    s_empty_cut |=> !o_update
  ) else $error("empty frame committed");

  a_update_once: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R9
    o_update |=> !o_update
  ) else $error("update pulse longer than one cycle");

  a_latch_quiet: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R9
    !commit |=> ($stable(o_code_a) && $stable(o_code_b) && $stable(o_hold_buf)
      && $stable(o_speed_fast) && $stable(o_power_down))
  ) else $error("latch moved without a commit");

  // target latches per select code
  a_reserved_keep: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R13
    (commit && !word[13] && word[15] && word[12])
      |=> ($stable(o_code_a) && $stable(o_code_b) && $stable(o_hold_buf))
  ) else $error("reserved code changed a latch");

  a_copy_buf: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R5
    (commit && !word[13] && word[15] && !word[12])
      |=> (o_code_b == $past(o_hold_buf) && o_code_a == $past(word[11:0]))
  ) else $error("code 10 load wrong");

  a_load_b_buf: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R4
    (commit && !word[13] && !word[15] && !word[12])
      |=> (o_code_b == $past(word[11:0]) && o_hold_buf == $past(word[11:0]))
  ) else $error("code 00 load wrong");

  a_buf_only: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R4
    (commit && !word[13] && !word[15] && word[12])
      |=> ($stable(o_code_b) && $stable(o_code_a) && o_hold_buf == $past(word[11:0]))
  ) else $error("code 01 load wrong");

  // program bits
  a_power_down: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R8
    (commit && word[13])
      |=> (o_power_down && $stable(o_code_a) && $stable(o_code_b) && $stable(o_hold_buf) && $stable(o_speed_fast))
  ) else $error("power-down word mishandled");

  a_power_clear: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R8
    s_word_taken |=> !o_power_down
  ) else $error("power-down not left");

  a_speed_sel: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R7
    s_word_taken |=> o_speed_fast == $past(word[14])
  ) else $error("speed not applied");

endmodule : ddl_loader

/* test/ddl_host.sv */
// serial host model that drives the loader pins
`timescale 1ns/1ps
module ddl_host (
  input wire logic i_mclk, // bench clock, only places the first pin change
  output logic o_sclk, // serial clock, idle high
  output logic o_cs_n, // chip select, active low
  output logic o_din   // serial data
);
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  task automatic frame_start;
    // offset keeps every later pin change clear of the sampling edge
    @(negedge i_mclk);
    #1.25 o_cs_n = 1'b0;
    #62.5;
  endtask : frame_start
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_din = b[i];
      #62.5 o_sclk = 1'b0;
      #62.5 o_sclk = 1'b1;
    end
  endtask : send_byte
  task automatic frame_end;
    #62.5 o_cs_n = 1'b1;
    o_din = ~o_din;
    #200;
  endtask : frame_end
  task automatic idle_clocks;
    @(negedge i_mclk);
    #1.25;
    repeat (16) begin
      #62.5 o_sclk = 1'b0;
      #62.5 o_sclk = 1'b1;
    end
  endtask : idle_clocks
endmodule : ddl_host

/* test/dual_dac_serial_word_loader_bench.sv */
// self-checking bench of the dual converter word loader
`timescale 1ns/1ps
module dual_dac_serial_word_loader_bench;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic sclk, cs_n, din, upd, settling_speed_select, pdn;
  logic [11:0] ca, cb, hb;
  int errors = 0;
  int compares = 0;
  int pulses = 0;
  ddl_loader u_ddl_loader (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .o_code_a(ca), .o_code_b(cb), .o_hold_buf(hb), .o_speed_fast(settling_speed_select), .o_power_down(pdn), .o_update(upd));
  ddl_host u_ddl_host (.i_mclk(i_mclk), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  always @(negedge i_mclk) begin
    if (upd === 1'b1) pulses++;
  end
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk3(input logic [11:0] a, input logic [11:0] b, input logic [11:0] h);
    chk("code_a", a, ca);
    chk("code_b", b, cb);
    chk("hold_buf", h, hb);
  endtask : chk3
  task automatic wr(input logic [15:0] w);
    int p;
    p = pulses;
    u_ddl_host.frame_start();
    u_ddl_host.send_byte(w[15:8]);
    u_ddl_host.send_byte(w[7:0]);
    u_ddl_host.frame_end();
    chk("pulses", 12'h001, 12'(pulses - p));
  endtask : wr
  task automatic t_load_b;
    u_ddl_host.frame_start();
    u_ddl_host.send_byte(8'h4a);
    u_ddl_host.send_byte(8'hbc);
    #55;
    chk3(12'h000, 12'habc, 12'habc);
    chk("speed", 12'h001, {11'h000, settling_speed_select});
    u_ddl_host.frame_end();
  endtask : t_load_b
  task automatic t_both;
    wr(16'h1123);
    chk3(12'h000, 12'habc, 12'h123);
    wr(16'h8456);
    chk3(12'h456, 12'h123, 12'h123);
    chk("speed", 12'h000, {11'h000, settling_speed_select});
  endtask : t_both
  task automatic t_reserved_power;
    wr(16'hd777);
    chk3(12'h456, 12'h123, 12'h123);
    chk("speed", 12'h001, {11'h000, settling_speed_select});
    wr(16'h2fff);
    chk("power", 12'h001, {11'h000, pdn});
    chk("speed", 12'h001, {11'h000, settling_speed_select});
    chk3(12'h456, 12'h123, 12'h123);
    wr(16'h0001);
    chk3(12'h456, 12'h001, 12'h001);
    chk("power", 12'h000, {11'h000, pdn});
    chk("speed", 12'h000, {11'h000, settling_speed_select});
  endtask : t_reserved_power
  task automatic t_framing;
    int p;
    p = pulses;
    u_ddl_host.idle_clocks();
    chk("pulses", 12'h000, 12'(pulses - p));
    chk3(12'h456, 12'h001, 12'h001);
    u_ddl_host.frame_start();
    u_ddl_host.frame_end();
    chk("pulses", 12'h000, 12'(pulses - p));
    // cut frame: eight bits land in the low byte of a cleared word
    u_ddl_host.frame_start();
    u_ddl_host.send_byte(8'hab);
    u_ddl_host.frame_end();
    chk("pulses", 12'h001, 12'(pulses - p));
    chk3(12'h456, 12'h0ab, 12'h0ab);
  endtask : t_framing
  task automatic t_reset;
    wr(16'hd000);
    wr(16'h2000);
    chk("flags", 12'h003, {10'h000, settling_speed_select, pdn});
    @(negedge i_mclk) i_reset_n = 1'b0;
    repeat (3) @(negedge i_mclk);
    i_reset_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    chk3(12'h000, 12'h000, 12'h000);
    chk("flags", 12'h000, {10'h000, settling_speed_select, pdn});
    wr(16'h4321);
    chk3(12'h000, 12'h321, 12'h321);
    chk("speed", 12'h001, {11'h000, settling_speed_select});
  endtask : t_reset
  task automatic conclude;
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge i_mclk);
    @(negedge i_mclk) i_reset_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    chk3(12'h000, 12'h000, 12'h000);
    chk("flags", 12'h000, {10'h000, settling_speed_select, pdn});
    t_load_b();
    t_both();
    t_reserved_power();
    t_framing();
    t_reset();
    conclude();
  end
  initial begin
    #100000;
    errors++;
    conclude();
  end
endmodule : dual_dac_serial_word_loader_bench
